/* logic/fsq_defines.vh */
// Opcodes, field positions and timing counts for the security/page-buffer flash host
`ifndef FSQ_DEFINES_VH
`define FSQ_DEFINES_VH
`define FSQ_OP_SEC_PROG 8'h9b
`define FSQ_OP_SEC_READ 8'h77
`define FSQ_OP_XFR_B1 8'h53
`define FSQ_OP_XFR_B2 8'h55
`define FSQ_OP_CMP_B1 8'h60
`define FSQ_OP_CMP_B2 8'h61
`define FSQ_OP_RW_B1 8'h58
`define FSQ_OP_RW_B2 8'h59
`define FSQ_OP_STATUS 8'hd7
`define FSQ_SEC_BYTES 8'd128
`define FSQ_SEC_USER 8'd64
`define FSQ_SEC_USER_LAST 8'd63
`define FSQ_SR_RDY_BIT 7
`define FSQ_SR_COMP_BIT 6
`define FSQ_SR_PGSZ_BIT 0
`define FSQ_PA_SHIFT_STD 9
`define FSQ_PA_SHIFT_BIN 8
`define FSQ_SCK_HALF 4'd4
`define FSQ_CMD_SEC_PROG 3'd0
`define FSQ_CMD_SEC_READ 3'd1
`define FSQ_CMD_XFR 3'd2
`define FSQ_CMD_CMP 3'd3
`define FSQ_CMD_RW 3'd4
`define FSQ_CMD_STATUS 3'd5
`endif

/* logic/fsq_mem.v */
// 128-byte store for security register data: written from user or link, registered read
module fsq_mem (
  input wire clk, // System clock
  input wire we, // Write strobe
  input wire [6:0] waddr, // Write address
  input wire [7:0] wdata, // Write data
  input wire [6:0] raddr, // Read address
  output reg [7:0] rdata // Registered read data
);
  reg [7:0] mem [0:127];

  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // fsq_mem

/* logic/fsq_host.v */
// SPI host sequencer for flash security register and page-buffer commands
`include "fsq_defines.vh"

// How it works
// - Program sends 9Bh,00h,00h,00h then the user data bytes.
// - Chip select rises after last data byte; host polls ready until done.
// - Host always sends all 64 user bytes in one program command.
// - Host programs the user half once; repeated requests are refused.
// - Read sends 77h plus three dummy bytes, then samples serial output.
// - Transfer uses 53h/55h; 264-byte mode: 3 dummy, 12 page bits, 9 dummy.
// - 256-byte mode: 4 dummy, 12 page bits, 8 dummy bits.
// - Chip select stays low through opcode and address bytes.
// - Compare uses 60h/61h with the same address layout.
// - Auto rewrite uses 58H/59H with the same address layout.
// - Software must schedule rewrites every 50,000 sector cycles; host only executes them.
module fsq_host (
  input wire clk, // 100 MHz system clock
  input wire rst, // Synchronous reset, active high
  input wire cmd_valid, // Command request
  output wire cmd_ready, // Host idle and can take a command
  input wire [2:0] cmd_code, // Command selector
  input wire cmd_buf2, // Select buffer 2 instead of buffer 1
  input wire [11:0] cmd_page, // Main memory page number
  input wire ud_we, // User writes a security byte into local store
  input wire [6:0] ud_addr, // Local store address for user write/read
  input wire [7:0] ud_wdata, // Local store write data
  output wire [7:0] ud_rdata, // Local store read data (one cycle latency)
  output reg done_r, // One-cycle pulse at end of command
  output reg refused_r, // One-cycle pulse when a command is refused
  output reg compare_diff_r, // Last compare mismatched
  output reg page_bin_r, // Device is in 256-byte page mode
  output reg sec_done_r, // User security half already programmed
  output reg [7:0] status_r, // Last status byte seen
  output reg sck_r, // Serial clock to device
  output reg cs_n_r, // Chip select to device, active low
  output reg si_r, // Serial data to device
  input wire so // Serial data from device
);
  localparam S_IDLE = 3'd0;
  localparam S_SHIFT = 3'd1;
  localparam S_GAP = 3'd2;
  localparam S_POLL = 3'd3;
  localparam S_DONE = 3'd4;

  // Phases of a frame
  localparam P_OP = 2'd0;
  localparam P_DATA_OUT = 2'd1;
  localparam P_DATA_IN = 2'd2;
  localparam P_STAT = 2'd3;
  localparam [7:0] OP_STAT = `FSQ_OP_STATUS;

  reg [2:0] state_r;
  reg [1:0] phase_r;
  reg [2:0] cmd_r;
  reg [31:0] hdr_r;
  reg [7:0] sh_r;
  reg [2:0] bit_r;
  reg [7:0] cnt_r;
  reg [3:0] div_r;
  reg so_m_r;
  reg so_s_r;
  reg [7:0] mem_addr_r;
  wire [7:0] mem_rd;
  reg mem_we;
  reg [7:0] mem_wd;

  function [7:0] cmd_opcode;
    input [2:0] c;
    input b2;
    begin
      case (c)
        `FSQ_CMD_SEC_PROG: cmd_opcode = `FSQ_OP_SEC_PROG;
        `FSQ_CMD_SEC_READ: cmd_opcode = `FSQ_OP_SEC_READ;
        `FSQ_CMD_XFR: cmd_opcode = b2 ? `FSQ_OP_XFR_B2 : `FSQ_OP_XFR_B1;
        `FSQ_CMD_CMP: cmd_opcode = b2 ? `FSQ_OP_CMP_B2 : `FSQ_OP_CMP_B1;
        `FSQ_CMD_RW: cmd_opcode = b2 ? `FSQ_OP_RW_B2 : `FSQ_OP_RW_B1;
        default: cmd_opcode = `FSQ_OP_STATUS;
      endcase
    end
  endfunction

  // Page field placed per the active page mode
  function [23:0] page_field;
    input [11:0] pg;
    input bin;
    begin
      if (bin) begin
        page_field = {4'h0, pg, 8'h00};
      end else begin
        page_field = {3'h0, pg, 9'h000};
      end
    end
  endfunction

  wire [7:0] op_now = cmd_opcode(cmd_code, cmd_buf2);

  assign cmd_ready = (state_r == S_IDLE);
  assign ud_rdata = mem_rd;

  fsq_mem u_mem (
    .clk(clk),
    .we(mem_we),
    .waddr(mem_we && cmd_ready ? ud_addr : mem_addr_r[6:0]),
    .wdata(mem_wd),
    .raddr(cmd_ready ? ud_addr : mem_addr_r[6:0]),
    .rdata(mem_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock divider: SCK edges every FSQ_SCK_HALF cycles, mode 0
  wire tick = (div_r == `FSQ_SCK_HALF - 4'd1);
  wire rise = tick && !sck_r && !cs_n_r;
  wire fall = tick && sck_r && !cs_n_r;
  wire last_bit = (bit_r == 3'd7);
  wire [7:0] rx_byte = {sh_r[6:0], so_s_r};

  always @(posedge clk) begin
    if (rst) begin
      so_m_r <= 1'b0;
      so_s_r <= 1'b0;
    end else begin
      so_m_r <= so;
      so_s_r <= so_m_r;
    end
  end

  always @* begin
    mem_we = 1'b0;
    mem_wd = ud_wdata;
    if (cmd_ready) begin
      mem_we = ud_we;
    end else if (state_r == S_SHIFT && phase_r == P_DATA_IN && fall && last_bit) begin
      mem_we = 1'b1;
      mem_wd = rx_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (rst) begin
      state_r <= S_IDLE;
      phase_r <= P_OP;
      cmd_r <= 3'd0;
      hdr_r <= 32'h00000000;
      sh_r <= 8'h00;
      bit_r <= 3'd0;
      cnt_r <= 8'h00;
      div_r <= 4'h0;
      mem_addr_r <= 8'h00;
      done_r <= 1'b0;
      refused_r <= 1'b0;
      compare_diff_r <= 1'b0;
      page_bin_r <= 1'b0;
      sec_done_r <= 1'b0;
      status_r <= 8'h00;
      sck_r <= 1'b0;
      cs_n_r <= 1'b1;
      si_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      refused_r <= 1'b0;
      div_r <= tick ? 4'h0 : div_r + 4'h1;
      case (state_r)
        S_IDLE: begin
          sck_r <= 1'b0;
          if (cmd_valid) begin
            if (cmd_code == `FSQ_CMD_SEC_PROG && sec_done_r) begin
              refused_r <= 1'b1;
            end else if (cmd_code > `FSQ_CMD_STATUS) begin
              refused_r <= 1'b1;
            end else begin
              cmd_r <= cmd_code;
              // Program header is 9Bh,00h,00h,00h; read header 77h + 3 dummies
              hdr_r <= {cmd_opcode(cmd_code, cmd_buf2),
                (cmd_code <= `FSQ_CMD_SEC_READ || cmd_code == `FSQ_CMD_STATUS) ? 24'h000000 :
                page_field(cmd_page, page_bin_r)};
              cnt_r <= (cmd_code == `FSQ_CMD_STATUS) ? 8'd2 : 8'd4;
              phase_r <= (cmd_code == `FSQ_CMD_STATUS) ? P_STAT : P_OP;
              mem_addr_r <= 8'h00;
              bit_r <= 3'd0;
              div_r <= 4'h0;
              cs_n_r <= 1'b0;
              si_r <= op_now[7];
              sh_r <= {op_now[6:0], 1'b0};
              state_r <= S_SHIFT;
            end
          end
        end
        S_SHIFT: begin
          if (rise) begin
            sck_r <= 1'b1;
          end
          if (fall) begin
            sck_r <= 1'b0;
            bit_r <= bit_r + 3'd1;
            // A status frame sends its opcode with cnt_r at 2, then receives with cnt_r at 1
            if (phase_r == P_DATA_IN || (phase_r == P_STAT && cnt_r == 8'd1)) begin
              sh_r <= rx_byte;
            end else begin
              si_r <= sh_r[7];
              sh_r <= {sh_r[6:0], 1'b0};
            end
            if (last_bit) begin
              cnt_r <= cnt_r - 8'd1;
              case (phase_r)
                P_OP: begin
                  hdr_r <= {hdr_r[23:0], 8'h00};
                  if (cnt_r != 8'd1) begin
                    si_r <= hdr_r[23];
                    sh_r <= {hdr_r[22:16], 1'b0};
                  end else if (cmd_r == `FSQ_CMD_SEC_PROG) begin
                    phase_r <= P_DATA_OUT;
                    cnt_r <= `FSQ_SEC_USER;
                    si_r <= mem_rd[7];
                    sh_r <= {mem_rd[6:0], 1'b0};
                    mem_addr_r <= 8'h01;
                  end else if (cmd_r == `FSQ_CMD_SEC_READ) begin
                    phase_r <= P_DATA_IN;
                    cnt_r <= `FSQ_SEC_BYTES;
                  end else begin
                    cs_n_r <= 1'b1;
                    state_r <= S_GAP;
                  end
                end
                P_DATA_OUT: begin
                  if (cnt_r == 8'd1) begin
                    cs_n_r <= 1'b1;
                    state_r <= S_GAP;
                  end else begin
                    si_r <= mem_rd[7];
                    sh_r <= {mem_rd[6:0], 1'b0};
                    mem_addr_r <= mem_addr_r + 8'd1;
                  end
                end
                P_DATA_IN: begin
                  mem_addr_r <= mem_addr_r + 8'd1;
                  if (cnt_r == 8'd1) begin
                    cs_n_r <= 1'b1;
                    state_r <= S_DONE;
                  end
                end
                default: begin
                  if (cnt_r != 8'd1) begin
                    // Opcode sent; SI idles low while the status byte comes in
                    si_r <= 1'b0;
                  end else begin
                    status_r <= rx_byte;
                    page_bin_r <= rx_byte[`FSQ_SR_PGSZ_BIT];
                    cs_n_r <= 1'b1;
                    state_r <= S_POLL;
                  end
                end
              endcase
            end
          end
        end
        S_GAP: begin
          // Chip select high for at least half an SCK period (FSQ_SCK_HALF cycles) before polling
          if (tick) begin
            cs_n_r <= 1'b0;
            cnt_r <= 8'd2;
            phase_r <= P_STAT;
            bit_r <= 3'd0;
            div_r <= 4'h0;
            si_r <= OP_STAT[7]; // MSB of status opcode
            sh_r <= {OP_STAT[6:0], 1'b0};
            state_r <= S_SHIFT;
          end
        end
        S_POLL: begin
          if (status_r[`FSQ_SR_RDY_BIT]) begin
            if (cmd_r == `FSQ_CMD_CMP) begin
              compare_diff_r <= status_r[`FSQ_SR_COMP_BIT];
            end
            state_r <= S_DONE;
          end else if (tick) begin
            state_r <= S_GAP;
          end
        end
        S_DONE: begin
          done_r <= 1'b1;
          cs_n_r <= 1'b1;
          if (cmd_r == `FSQ_CMD_SEC_PROG) begin
            sec_done_r <= 1'b1;
          end
          state_r <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule // fsq_host

/* dv/fsq_host_asserts.sv */
// Pin protocol and handshake checker for the flash host
module fsq_host_chk (
  input wire clk, // clock
  input wire rst, // reset
  input wire cmd_valid, // request
  input wire cmd_ready, // idle
  input wire [2:0] cmd_code, // command
  input wire cmd_buf2, // buffer 2
  input wire [11:0] cmd_page, // page
  input wire ud_we, // store write
  input wire [6:0] ud_addr, // store address
  input wire [7:0] ud_wdata, // store data
  input wire [7:0] ud_rdata, // store read
  input wire done_r, // end pulse
  input wire refused_r, // refusal
  input wire compare_diff_r, // compare flag
  input wire page_bin_r, // page mode
  input wire sec_done_r, // programmed
  input wire [7:0] status_r, // status
  input wire sck_r, // serial clock
  input wire cs_n_r, // select
  input wire si_r, // serial out of host
  input wire so // serial in to host
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  wire take = cmd_valid && cmd_ready;
  wire bad = cmd_code > 3'h5 || (cmd_code == 3'h0 && sec_done_r);
  ////////////////////
  a_reset_idle: assert property ($past(rst) |-> cs_n_r && !sck_r)
    else $error("pins not idle after reset");
  a_sck_selected: assert property (sck_r |-> !cs_n_r)
    else $error("clock pulse while deselected");
  a_sck_half: assert property ($rose(sck_r) |-> sck_r [*4] ##1 !sck_r)
    else $error("serial clock high phase wrong");
  a_si_hold: assert property (sck_r && $past(sck_r) |-> $stable(si_r))
    else $error("data moved while clock high");
  a_take_select: assert property (take && !bad |-> ##[1:2] !cs_n_r)
    else $error("accepted command did not select");
  a_bad_refused: assert property (take && bad |=> refused_r)
    else $error("illegal command not refused");
  a_done_pulse: assert property (done_r |=> !done_r)
    else $error("done longer than one cycle");
  a_done_deselect: assert property (done_r |-> cs_n_r)
    else $error("done while selected");
  a_once_only: assert property (sec_done_r |=> sec_done_r)
    else $error("programmed flag dropped");
  a_ready_idle: assert property (cmd_ready |-> cs_n_r)
    else $error("ready while selected");
endmodule // fsq_host_chk

bind fsq_host fsq_host_chk chk (.clk, .rst, .cmd_valid, .cmd_ready, .cmd_code, .cmd_buf2, .cmd_page, .ud_we,
  .ud_addr, .ud_wdata, .ud_rdata, .done_r, .refused_r, .compare_diff_r, .page_bin_r, .sec_done_r, .status_r,
  .sck_r, .cs_n_r, .si_r, .so);

/* dv/fsq_flash_model.sv */
// Behavioural serial flash: security register, status and page-buffer commands
module fsq_flash_model (
  input wire clk, // times busy periods
  input wire sck, // serial clock
  input wire cs_n, // select, active low
  input wire si, // serial in
  output reg so // serial out
);
  timeunit 1ns;
  timeprecision 1ns;
  parameter int BUSY = 40;
  logic [7:0] sec [0:127];
  logic [7:0] pend [0:63];
  logic [7:0] sh = 8'h00, op = 8'h00;
  logic [23:0] addr = 24'h000000;
  logic rdy = 1'b1, comp = 1'b0, pgsz = 1'b0, otp = 1'b0;
  int cnt = 0, nb = 0, last_nb = 0;
  // Last non-status frame, so that status polling does not hide what the host sent
  logic [7:0] last_op = 8'h00;
  logic [11:0] last_pg = 12'h000;
  wire [11:0] pg = pgsz ? addr[19:8] : addr[20:9];
  initial begin
    so = 1'b0;
    for (int i = 0; i < 128; i++) begin
      sec[i] = i < 64 ? 8'hff : 8'(i) ^ 8'h5a;
    end
  end
  ////////////////////
  // Busy is timed in system clocks so the host must really poll
  task automatic run(input logic c);
    rdy = 1'b0;
    fork
      begin
        repeat (BUSY) @(posedge clk);
        comp = c;
        rdy = 1'b1;
      end
    join_none
  endtask
  always @(negedge cs_n) cnt = 0;
  always @(posedge sck) begin
    if (!cs_n) begin
      sh = {sh[6:0], si};
      cnt++;
      nb = cnt / 8;
      if (cnt % 8 == 0 && nb == 1) op = sh;
      else if (cnt % 8 == 0 && nb <= 4 && op != 8'hd7) addr = {addr[15:0], sh};
      else if (cnt % 8 == 0 && op == 8'h9b) pend[(nb - 5) % 64] = sh;
    end
  end
  // Undriven output toggles so a stale bit is never mistaken for data
  always @(negedge sck) begin
    if (!cs_n && op == 8'h77 && cnt >= 32) so = cnt < 1056 ? sec[cnt / 8 - 4][7 - cnt % 8] : ~so;
    else if (!cs_n && op == 8'hd7 && cnt >= 8) so = ((cnt / 8) % 2 ? {rdy, comp, 5'h00, pgsz} : {rdy, 7'h00}) >> (7 - cnt % 8);
    else so = ~so;
  end
  always @(posedge cs_n) begin
    so = ~so;
    if (op != 8'hd7) begin
      last_op = op;
      last_nb = nb;
      last_pg = pg;
    end
    if (op == 8'h9b && nb >= 5 && !otp) begin
      for (int i = 0; i < 64; i++) sec[i] = pend[i];
      otp = 1'b1;
      run(comp);
    end else if (nb >= 4 && op inside {8'h53, 8'h55, 8'h58, 8'h59}) begin
      run(comp);
    end else if (nb >= 4 && op inside {8'h60, 8'h61}) begin
      run(pg[0]);
    end
  end
endmodule // fsq_flash_model

/* dv/test_fsq_host.sv */
// Self-checking bench for the flash host sequencer
module test_fsq_host;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, cmd_valid = 0, cmd_buf2 = 0, ud_we = 0;
  logic [2:0] cmd_code = 3'h0;
  logic [11:0] cmd_page = 12'h000;
  logic [6:0] ud_addr = 7'h00;
  logic [7:0] ud_wdata = 8'h00, ud_rdata, status_r;
  logic cmd_ready, done_r, refused_r, compare_diff_r, page_bin_r, sec_done_r, sck_r, cs_n_r, si_r, so;
  int miscompares = 0, check_count = 0, cyc = 0;
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
  fsq_host dut (.clk, .rst, .cmd_valid, .cmd_ready, .cmd_code, .cmd_buf2, .cmd_page, .ud_we, .ud_addr,
    .ud_wdata, .ud_rdata, .done_r, .refused_r, .compare_diff_r, .page_bin_r, .sec_done_r, .status_r,
    .sck_r, .cs_n_r, .si_r, .so);
  // Busy outlasts one status frame so the host has to poll more than once
  fsq_flash_model #(.BUSY(200)) flash (.clk, .sck(sck_r), .cs_n(cs_n_r), .si(si_r), .so);
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      miscompares++;
      end_of_test();
    end
  end
  ////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Ready is high in idle, so the request is taken at the first edge
  task automatic cmd(input logic [2:0] c, input logic b2, input logic [11:0] pg);
    @(posedge clk);
    #1;
    cmd_code = c;
    cmd_buf2 = b2;
    cmd_page = pg;
    cmd_valid = 1;
    @(posedge clk);
    #1;
    cmd_valid = 0;
    for (int n = 0; n < 30000 && done_r !== 1 && refused_r !== 1; n++) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic peek(input logic [6:0] a, input logic [7:0] e);
    @(posedge clk);
    #1;
    ud_addr = a;
    repeat (2) @(posedge clk);
    #1;
    `CHK(ud_rdata, e)
  endtask
  ////////////////////
  task automatic t_read();
    cmd(3'h1, 0, 12'h000);
    `CHK(flash.last_op, 8'h77)
    `CHK(flash.last_nb, 132)
    peek(7'h00, 8'hff);
    peek(7'h40, 8'h40 ^ 8'h5a);
    peek(7'h7f, 8'h7f ^ 8'h5a);
    $display("read test ended");
  endtask
  task automatic t_prog();
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      #1;
      ud_we = 1;
      ud_addr = 7'(i);
      ud_wdata = 8'(i + 3);
    end
    @(posedge clk);
    #1;
    ud_we = 0;
    cmd(3'h0, 0, 12'h000);
    `CHK(flash.last_nb, 68)
    `CHK(flash.rdy, 1'b1)
    `CHK(sec_done_r, 1'b1)
    cmd(3'h1, 0, 12'h000);
    peek(7'h00, 8'h03);
    peek(7'h3f, 8'h42);
    peek(7'h41, 8'h41 ^ 8'h5a);
    cmd(3'h0, 0, 12'h000);
    `CHK(refused_r, 1'b1)
    cmd(3'h6, 0, 12'h000);
    `CHK(refused_r, 1'b1)
    $display("program test ended");
  endtask
  task automatic t_page();
    logic [7:0] ops [0:5] = '{8'h53, 8'h55, 8'h60, 8'h61, 8'h58, 8'h59};
    logic [11:0] pg;
    for (int m = 0; m < 2; m++) begin
      flash.pgsz = m[0];
      cmd(3'h5, 0, 12'h000);
      `CHK(page_bin_r, m[0])
      `CHK(status_r[7], 1'b1)
      for (int k = 0; k < 6; k++) begin
        pg = 12'hf00 | 12'(k + 8 * m);
        cmd(3'(2 + k / 2), k[0], pg);
        `CHK(flash.last_op, ops[k])
        `CHK(flash.last_nb, 4)
        `CHK(flash.last_pg, pg)
        `CHK(flash.rdy, 1'b1)
        if (k / 2 == 1) `CHK(compare_diff_r, pg[0])
      end
    end
    $display("page test ended");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst = 0;
    t_read();
    t_prog();
    t_page();
    end_of_test();
  end
endmodule // test_fsq_host
